// *** verilog/ssr_pkg.sv ***
package ssr_pkg;
  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int unsigned       SSR_W          = 16;
  localparam logic [15:0]       SSR_RST_WORD   = 16'h0000;
  localparam logic [2:0]        SSR_RST_CNT    = 3'h0;
  localparam logic [2:0]        SSR_CNT_MAX    = 3'h4;
  localparam logic [15:0]       SSR_RST_STATUS = 16'h0001;
  localparam int unsigned       SSR_MODE_BIT   = 0;
  localparam logic [15:0]       SSR_OVERRUN    = 16'h000d;

  // ****************************************
  // Register select codes
  // ****************************************
  localparam logic [3:0] SSR_R_DL   = 4'h0;
  localparam logic [3:0] SSR_R_DB   = 4'h1;
  localparam logic [3:0] SSR_R_FMP  = 4'h2;
  localparam logic [3:0] SSR_R_SMT  = 4'h3;
  localparam logic [3:0] SSR_R_CNT  = 4'h4;
  localparam logic [3:0] SSR_R_LIM  = 4'h5;
  localparam logic [3:0] SSR_R_IDX  = 4'h6;
  localparam logic [3:0] SSR_R_STAT = 4'h7;
  localparam logic [3:0] SSR_R_MASK = 4'h8;
  localparam logic [3:0] SSR_R_STOP = 4'h9;

  // ****************************************
  // Instruction field positions
  // ****************************************
  localparam int unsigned SSR_MODE_HI = 9;
  localparam int unsigned SSR_MODE_LO = 6;

  // Addressing modes in bits 6..9 (project encoding)
  typedef enum logic [5:0]
  {
    SSR_AM_PCF = 6'b000001,
    SSR_AM_PCB = 6'b000010,
    SSR_AM_DBF = 6'b000100,
    SSR_AM_FMF = 6'b001000,
    SSR_AM_FMB = 6'b010000,
    SSR_AM_STB = 6'b100000
  } ssr_am_t;

  // Operations from the decoder
  typedef enum logic [3:0]
  {
    SSR_OP_NONE  = 4'h0,
    SSR_OP_WRITE = 4'h1,
    SSR_OP_SET_REGISTERS_OP  = 4'h2,
    SSR_OP_LMSK  = 4'h3,
    SSR_OP_READ_INTERRUPT_MASK_OP  = 4'h4,
    SSR_OP_EXIT  = 4'h5,
    SSR_OP_LRA   = 4'h6,
    SSR_OP_ABS   = 4'h7,
    SSR_OP_PRIV  = 4'h8,
    SSR_OP_UCALL = 4'h9,
    SSR_OP_PCSET = 4'ha
  } ssr_op_t;

  // Decode the mode field of an instruction word
  function automatic ssr_am_t ssr_mode(input logic [15:0] ins);
    logic [3:0] m;
    m = ins[SSR_MODE_HI:SSR_MODE_LO];
    // Two-bit code in ins[9:8] keeps ins[7:0] free for the displacement in three modes; code 11 also decodes ins[7:6]
    if (m[3:2] == 2'b00)
      ssr_mode = SSR_AM_PCF;
    else if (m[3:2] == 2'b01)
      ssr_mode = SSR_AM_PCB;
    else if (m[3:2] == 2'b10)
      ssr_mode = SSR_AM_DBF;
    else if (m[1] == 1'b0)
      ssr_mode = SSR_AM_FMF;
    else if (m[0] == 1'b0)
      ssr_mode = SSR_AM_FMB;
    else
      ssr_mode = SSR_AM_STB;
  endfunction
endpackage

// *** verilog/ssr_ptr_if.sv ***
interface ssr_ptr_if;
  import ssr_pkg::*;
  logic [15:0] data_base;
  logic [15:0] frame_ptr;
  logic [15:0] stack_mem_top;
  logic [2:0]  stack_reg_count;
  logic [15:0] stack_limit;
  logic [15:0] program_base;
  logic [15:0] program_counter;
  logic [15:0] index_val;
  logic [15:0] ins;
  logic        use_index;
  logic [15:0] eff_addr;
  logic [15:0] rel_addr;
  logic [15:0] logical_top;
  logic [2:0]  tos_slot;
  logic        in_tos;
  modport regs (output data_base, frame_ptr, stack_mem_top, stack_reg_count, stack_limit,
                output program_base, program_counter, index_val, ins, use_index,
                input eff_addr, rel_addr, logical_top, tos_slot, in_tos);
  modport agen (input data_base, frame_ptr, stack_mem_top, stack_reg_count, stack_limit,
                input program_base, program_counter, index_val, ins, use_index,
                output eff_addr, rel_addr, logical_top, tos_slot, in_tos);
endinterface

// *** verilog/ssr_agen.sv ***
module ssr_agen
  import ssr_pkg::*;
(
  ssr_ptr_if.agen p
);
  import ssr_pkg::*;

  // ****************************************
  // Mode and displacement
  // ****************************************
  ssr_am_t     am;
  logic [15:0] disp;
  logic [15:0] base_addr;
  logic [15:0] dir_addr;
  logic [15:0] top;
  logic [15:0] tos_dist;
  logic        tos_mode;

  assign am   = ssr_mode(p.ins);
  // Field width follows the mode
  assign disp = (am == SSR_AM_FMF) ? {9'h000, p.ins[6:0]} :
                (am == SSR_AM_FMB || am == SSR_AM_STB) ? {10'h000, p.ins[5:0]} :
                {8'h00, p.ins[7:0]};

  // Logical top formed, not stored
  assign top = 16'(p.stack_mem_top + {13'h0000, p.stack_reg_count});

  // Direction per base: forward adds, backward subtracts, wrapping
  always_comb
  begin
    case (am)
      SSR_AM_PCF: dir_addr = 16'(p.program_counter + disp);
      SSR_AM_PCB: dir_addr = 16'(p.program_counter - disp);
      SSR_AM_DBF: dir_addr = 16'(p.data_base + disp);
      SSR_AM_FMF: dir_addr = 16'(p.frame_ptr + disp);
      SSR_AM_FMB: dir_addr = 16'(p.frame_ptr - disp);
      SSR_AM_STB: dir_addr = 16'(top - disp);
      default:    dir_addr = p.program_counter;
    endcase
  end

  // Displacement then indexing, modulo 65536
  assign p.eff_addr    = p.use_index ? 16'(dir_addr + p.index_val) : dir_addr;
  assign base_addr     = (am == SSR_AM_PCF || am == SSR_AM_PCB) ? p.program_base : p.data_base;
  assign p.rel_addr    = 16'(p.eff_addr - base_addr);
  assign p.logical_top = top;

  // Words above stack_mem_top live in registers
  assign tos_mode   = (am == SSR_AM_DBF || am == SSR_AM_FMF || am == SSR_AM_STB);
  assign tos_dist   = 16'(top - p.eff_addr);
  assign p.in_tos   = tos_mode && (tos_dist < {13'h0000, p.stack_reg_count});
  assign p.tos_slot = tos_dist[2:0];
endmodule

// *** verilog/ssr_top.sv ***
// What this block does
// - Data limit holds 16-bit user space start
// - Data base holds 16-bit global area start
// - Frame pointer holds fourth marker word address
// - Set-registers writes frame pointer; exit checks bounds
// - Stack memory top bounded by limit, and by base in user mode only
// - Stack register count three bits, zero to four
// - Logical top is memory top plus count
// - Stack limit 16-bit; thirteen overrun words follow
// - Index register readable, writable, supplies index
// - Mask bit one enables its interrupt group
// - Mask load privileged; mask read always allowed
// - Privileged ops and uncallable calls need privilege
// - Status bit zero shows mode; privileged change
// - Absolute addressing only for privileged operations
// - Program, frame both ways; base forward; top backward
// - Two-bit mode, 8-bit displacement for three modes
// - Frame forward displacement bits 9-15, 0-127
// - Frame, top backward displacement bits 10-15, 0-63
// - Base, frame forward, top backward references into top registers use register copy
// - Effective address: displacement then indexing
// - Relative address is effective minus base
// - Address arithmetic wraps modulo 65536
// - Program counter outside code bounds raises violation
module ssr_top
  import ssr_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic           rst_n,
  input  wire logic           clk_en,
  input  wire ssr_pkg::ssr_op_t op,
  input  wire logic [3:0]     reg_sel,
  input  wire logic [15:0]    wr_data,
  input  wire logic [15:0]    ins,
  input  wire logic           use_index,
  input  wire logic [15:0]    program_base,
  input  wire logic [15:0]    program_limit,
  input  wire logic [15:0]    pc_target,
  input  wire logic [15:0]    ext_irq,
  output logic [15:0]         rd_data,
  output logic [15:0]         eff_addr,
  output logic [15:0]         rel_addr,
  output logic [15:0]         logical_top,
  output logic                in_tos,
  output logic [2:0]          tos_slot,
  output logic                priv_mode,
  output logic                priv_fault,
  output logic                bounds_fault,
  output logic                pc_violation,
  output logic [15:0]         program_counter,
  output logic [15:0]         irq_enabled
);
  import ssr_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  logic [15:0] data_limit_q,      data_limit_d;
  logic [15:0] data_base_q,       data_base_d;
  logic [15:0] frame_marker_q,    frame_marker_d;
  logic [15:0] stack_mem_top_q,   stack_mem_top_d;
  logic [2:0]  stack_reg_count_q, stack_reg_count_d;
  logic [15:0] stack_limit_q,     stack_limit_d;
  logic [15:0] index_q,           index_d;
  logic [15:0] status_q,          status_d;
  logic [15:0] mask_q,            mask_d;
  logic [15:0] pc_q,              pc_d;
  logic [15:0] rd_q,              rd_d;
  logic [15:0] irq_sync1_q,       irq_sync2_q;
  logic        priv_fault_q,      priv_fault_d;
  logic        bounds_fault_q,    bounds_fault_d;
  logic        pc_viol_q,         pc_viol_d;

  ssr_ptr_if   pif ();

  // ****************************************
  // Address generator
  // ****************************************
  assign pif.data_base       = data_base_q;
  assign pif.frame_ptr       = frame_marker_q;
  assign pif.stack_mem_top   = stack_mem_top_q;
  assign pif.stack_reg_count = stack_reg_count_q;
  assign pif.stack_limit     = stack_limit_q;
  assign pif.program_base    = program_base;
  assign pif.program_counter = pc_q;
  assign pif.index_val       = index_q;
  assign pif.ins             = ins;
  assign pif.use_index       = use_index;

  ssr_agen u_agen
  (
    .p (pif.agen)
  );

  // ****************************************
  // Decode
  // ****************************************
  logic        is_priv;
  logic        wr_op;
  logic        set_registers_op_op;
  logic        set_registers_op;
  logic        load_interrupt_mask_op;
  logic        read_interrupt_mask_op;
  logic        load_relative_address_op;
  logic        exit_op;
  logic        abs_op;
  logic        priv_only_op;
  logic        pc_set_op;
  logic        cnt_ok;
  logic        fm_ok;
  logic        smt_ok;
  logic        pc_ok;
  logic        sel_is_priv;
  logic        wr_allowed;
  logic [15:0] new_status;

  assign is_priv                  = status_q[SSR_MODE_BIT];
  assign wr_op                    = (op == SSR_OP_WRITE);
  assign set_registers_op         = (op == SSR_OP_SET_REGISTERS_OP);
  assign set_registers_op_op                  = wr_op | set_registers_op;
  assign load_interrupt_mask_op   = (op == SSR_OP_LMSK);
  assign read_interrupt_mask_op   = (op == SSR_OP_READ_INTERRUPT_MASK_OP);
  assign load_relative_address_op = (op == SSR_OP_LRA);
  assign exit_op                  = (op == SSR_OP_EXIT);
  assign abs_op                   = (op == SSR_OP_ABS);
  assign priv_only_op             = (op == SSR_OP_PRIV) | (op == SSR_OP_UCALL) | abs_op;
  assign pc_set_op                = (op == SSR_OP_PCSET);

  // Count limited to 0..4
  assign cnt_ok = (wr_data[2:0] <= SSR_CNT_MAX);

  // Bounds: at or below limit, at or above base unless privileged
  assign fm_ok  = (frame_marker_q <= stack_limit_q) &&
                  (is_priv || frame_marker_q >= data_base_q);
  assign smt_ok = (wr_data <= stack_limit_q) &&
                  (is_priv || wr_data >= data_base_q);
  assign pc_ok  = (pc_target >= program_base) && (pc_target <= program_limit);

  // Base, limit, mode, mask writes are supervisor only
  assign sel_is_priv = (reg_sel == SSR_R_DL) || (reg_sel == SSR_R_DB) ||
                       (reg_sel == SSR_R_LIM) || (reg_sel == SSR_R_STAT) ||
                       (reg_sel == SSR_R_MASK);
  assign wr_allowed  = set_registers_op_op && (is_priv || !sel_is_priv);

  // A user write keeps the mode bit, but user status writes are refused as supervisor only
  assign new_status = is_priv ? wr_data : {wr_data[15:1], status_q[SSR_MODE_BIT]};

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    data_limit_d      = data_limit_q;
    data_base_d       = data_base_q;
    frame_marker_d    = frame_marker_q;
    stack_mem_top_d   = stack_mem_top_q;
    stack_reg_count_d = stack_reg_count_q;
    stack_limit_d     = stack_limit_q;
    index_d           = index_q;
    status_d          = status_q;
    mask_d            = mask_q;
    pc_d              = pc_q;
    rd_d              = rd_q;
    priv_fault_d      = 1'b0;
    bounds_fault_d    = 1'b0;
    pc_viol_d         = 1'b0;
    if (set_registers_op_op && !wr_allowed)
      priv_fault_d = 1'b1;
    if (priv_only_op && !is_priv)
      priv_fault_d = 1'b1;
    if (wr_allowed)
    begin
      case (reg_sel)
        SSR_R_DL:   data_limit_d  = wr_data;
        SSR_R_DB:   data_base_d   = wr_data;
        SSR_R_FMP:  frame_marker_d = wr_data;
        SSR_R_SMT:
        begin
          if (smt_ok)
            stack_mem_top_d = wr_data;
          else
            bounds_fault_d = 1'b1;
        end
        SSR_R_CNT:
        begin
          if (cnt_ok)
            stack_reg_count_d = wr_data[2:0];
          else
            bounds_fault_d = 1'b1;
        end
        SSR_R_LIM:  stack_limit_d = wr_data;
        SSR_R_IDX:  index_d       = wr_data;
        SSR_R_STAT: status_d      = new_status;
        SSR_R_MASK: mask_d        = wr_data;
        default:    priv_fault_d  = priv_fault_d;
      endcase
    end
    if (load_interrupt_mask_op)
    begin
      if (is_priv)
        mask_d = wr_data;
      else
        priv_fault_d = 1'b1;
    end
    if (exit_op && !fm_ok)
      bounds_fault_d = 1'b1;
    if (pc_set_op)
    begin
      if (pc_ok)
        pc_d = pc_target;
      else
        pc_viol_d = 1'b1;
    end
    // Register reads
    if (read_interrupt_mask_op)
      rd_d = mask_q;
    else if (load_relative_address_op)
      rd_d = pif.rel_addr;
    else if (op == SSR_OP_NONE)
    begin
      case (reg_sel)
        SSR_R_DL:   rd_d = data_limit_q;
        SSR_R_DB:   rd_d = data_base_q;
        SSR_R_FMP:  rd_d = frame_marker_q;
        SSR_R_SMT:  rd_d = stack_mem_top_q;
        SSR_R_CNT:  rd_d = {13'h0000, stack_reg_count_q};
        SSR_R_LIM:  rd_d = stack_limit_q;
        SSR_R_IDX:  rd_d = index_q;
        SSR_R_STAT: rd_d = status_q;
        SSR_R_MASK: rd_d = mask_q;
        SSR_R_STOP: rd_d = pif.logical_top;
        default:    rd_d = SSR_RST_WORD;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_limit_q      <= SSR_RST_WORD;
      data_base_q       <= SSR_RST_WORD;
      frame_marker_q    <= SSR_RST_WORD;
      stack_mem_top_q   <= SSR_RST_WORD;
      stack_reg_count_q <= SSR_RST_CNT;
      stack_limit_q     <= SSR_RST_WORD;
      index_q           <= SSR_RST_WORD;
      status_q          <= SSR_RST_STATUS;
      mask_q            <= SSR_RST_WORD;
      pc_q              <= SSR_RST_WORD;
      rd_q              <= SSR_RST_WORD;
      priv_fault_q      <= 1'b0;
      bounds_fault_q    <= 1'b0;
      pc_viol_q         <= 1'b0;
    end
    else if (clk_en)
    begin
      data_limit_q      <= data_limit_d;
      data_base_q       <= data_base_d;
      frame_marker_q    <= frame_marker_d;
      stack_mem_top_q   <= stack_mem_top_d;
      stack_reg_count_q <= stack_reg_count_d;
      stack_limit_q     <= stack_limit_d;
      index_q           <= index_d;
      status_q          <= status_d;
      mask_q            <= mask_d;
      pc_q              <= pc_d;
      rd_q              <= rd_d;
      priv_fault_q      <= priv_fault_d;
      bounds_fault_q    <= bounds_fault_d;
      pc_viol_q         <= pc_viol_d;
    end
  end

  // External interrupt lines pass two flops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_sync1_q <= SSR_RST_WORD;
      irq_sync2_q <= SSR_RST_WORD;
    end
    else if (clk_en)
    begin
      irq_sync1_q <= ext_irq;
      irq_sync2_q <= irq_sync1_q;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rd_data         = rd_q;
  assign eff_addr        = pif.eff_addr;
  assign rel_addr        = pif.rel_addr;
  assign logical_top     = pif.logical_top;
  assign in_tos          = pif.in_tos;
  assign tos_slot        = pif.tos_slot;
  assign priv_mode       = is_priv;
  assign priv_fault      = priv_fault_q;
  assign bounds_fault    = bounds_fault_q;
  assign pc_violation    = pc_viol_q;
  assign program_counter = pc_q;
  assign irq_enabled     = irq_sync2_q & mask_q;
endmodule

// *** dv/ssr_assertions.sv ***
// ****************************************
// Port checker for the register set
// ****************************************
module ssr_checker
  import ssr_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             rst_n,
  input wire logic             clk_en,
  input wire ssr_pkg::ssr_op_t op,
  input wire logic [15:0]      ins,
  input wire logic             use_index,
  input wire logic [15:0]      program_base,
  input wire logic [15:0]      program_limit,
  input wire logic [15:0]      pc_target,
  input wire logic [15:0]      ext_irq,
  input wire logic [15:0]      eff_addr,
  input wire logic [15:0]      rel_addr,
  input wire logic             priv_mode,
  input wire logic             priv_fault,
  input wire logic             pc_violation,
  input wire logic [15:0]      program_counter,
  input wire logic [15:0]      irq_enabled
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Mode, privilege, code bounds, interrupts and PC addressing
  a_user_stays_user: assert property (!priv_mode |=> !priv_mode) else $error("mode left user");
  a_lmsk_user_fault: assert property (clk_en && op == SSR_OP_LMSK && !priv_mode |=> priv_fault)
    else $error("mask load not refused");
  a_read_interrupt_mask_op_never_fault: assert property (clk_en && op == SSR_OP_READ_INTERRUPT_MASK_OP |=> !priv_fault)
    else $error("mask read refused");
  a_priv_op_fault: assert property (clk_en && op inside {SSR_OP_PRIV, SSR_OP_UCALL, SSR_OP_ABS} && !priv_mode
    |=> priv_fault) else $error("user privileged op passed");
  a_priv_op_ok: assert property (clk_en && op inside {SSR_OP_PRIV, SSR_OP_UCALL, SSR_OP_ABS} && priv_mode
    |=> !priv_fault) else $error("privileged op refused");
  a_pc_refuse_out: assert property (clk_en && op == SSR_OP_PCSET && (pc_target < program_base ||
    pc_target > program_limit) |=> pc_violation && $stable(program_counter)) else $error("pc left bounds");
  a_pc_load_in: assert property (clk_en && op == SSR_OP_PCSET && pc_target >= program_base &&
    pc_target <= program_limit |=> program_counter == $past(pc_target) && !pc_violation) else $error("pc not set");
  a_irq_quiet_zero: assert property ((clk_en && ext_irq == 16'h0000)[*3] |=> irq_enabled == 16'h0000)
    else $error("irq without source");
  a_pc_fwd_addr: assert property (ins[9:8] == 2'b00 && !use_index |->
    eff_addr == program_counter + {8'h00, ins[7:0]}) else $error("pc forward address");
  a_pc_rel_addr: assert property (ins[9] == 1'b0 |-> rel_addr == eff_addr - program_base)
    else $error("pc relative address");

  // Main scenarios reached
  c_pc_refused: cover property (clk_en && op == SSR_OP_PCSET ##1 pc_violation);
  c_priv_fault: cover property (priv_fault);
  c_user_mode: cover property (!priv_mode);
endmodule

bind ssr_top ssr_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .op(op), .ins(ins),
  .use_index(use_index), .program_base(program_base), .program_limit(program_limit), .pc_target(pc_target),
  .ext_irq(ext_irq), .eff_addr(eff_addr), .rel_addr(rel_addr), .priv_mode(priv_mode), .priv_fault(priv_fault),
  .pc_violation(pc_violation), .program_counter(program_counter), .irq_enabled(irq_enabled));

// *** dv/tb_top.sv ***
// ****************************************
// Register set testbench
// ****************************************
module tb_top
  import ssr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst_n, clk_en, use_index, in_tos, priv_mode, priv_fault, bounds_fault, pc_violation;
  ssr_op_t     op;
  logic [3:0]  reg_sel;
  logic [2:0]  tos_slot;
  logic [15:0] wr_data, ins, program_base, program_limit, pc_target, ext_irq, rd_data;
  logic [15:0] eff_addr, rel_addr, logical_top, program_counter, irq_enabled;
  int          err_total = 0;
  int          num_checks = 0;

  ssr_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .op(op), .reg_sel(reg_sel), .wr_data(wr_data),
    .ins(ins), .use_index(use_index), .program_base(program_base), .program_limit(program_limit),
    .pc_target(pc_target), .ext_irq(ext_irq), .rd_data(rd_data), .eff_addr(eff_addr), .rel_addr(rel_addr),
    .logical_top(logical_top), .in_tos(in_tos), .tos_slot(tos_slot), .priv_mode(priv_mode),
    .priv_fault(priv_fault), .bounds_fault(bounds_fault), .pc_violation(pc_violation),
    .program_counter(program_counter), .irq_enabled(irq_enabled));

  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One operation, then its fault pulses
  task automatic run(input ssr_op_t o, input logic [3:0] s, input logic [15:0] d, input logic [1:0] ef);
    @(negedge sys_clk);
    op = o;
    reg_sel = s;
    wr_data = d;
    @(negedge sys_clk);
    op = SSR_OP_NONE;
    chk("faults", {14'h0, ef}, {14'h0, priv_fault, bounds_fault});
  endtask

  task automatic rd(input logic [3:0] s, input logic [15:0] e);
    @(negedge sys_clk);
    reg_sel = s;
    @(negedge sys_clk);
    chk("read", e, rd_data);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 10; i++)
      rd(i[3:0], (i == 7) ? SSR_RST_STATUS : 16'h0000);
    chk("mode", 16'h0001, {15'h0, priv_mode});
    $display("t_reset done");
  endtask

  task automatic t_stack();
    run(SSR_OP_WRITE, SSR_R_DB, 16'h1000, 2'b00);
    run(SSR_OP_WRITE, SSR_R_LIM, 16'h2000, 2'b00);
    run(SSR_OP_WRITE, SSR_R_DL, 16'h0f00, 2'b00);
    run(SSR_OP_WRITE, SSR_R_SMT, 16'h0800, 2'b00);
    run(SSR_OP_WRITE, SSR_R_SMT, 16'h1ffe, 2'b00);
    run(SSR_OP_WRITE, SSR_R_SMT, 16'h2001, 2'b01);
    run(SSR_OP_WRITE, SSR_R_CNT, 16'h0004, 2'b00);
    run(SSR_OP_WRITE, SSR_R_CNT, 16'h0005, 2'b01);
    rd(SSR_R_SMT, 16'h1ffe);
    rd(SSR_R_STOP, 16'h2002);
    chk("top", 16'h2002, logical_top);
    rd(SSR_R_DL, 16'h0f00);
    run(SSR_OP_SET_REGISTERS_OP, SSR_R_FMP, 16'h2100, 2'b00);
    run(SSR_OP_EXIT, 4'h0, 16'h0000, 2'b01);
    run(SSR_OP_SET_REGISTERS_OP, SSR_R_FMP, 16'h0800, 2'b00);
    run(SSR_OP_EXIT, 4'h0, 16'h0000, 2'b00);
    run(SSR_OP_SET_REGISTERS_OP, SSR_R_FMP, 16'h1800, 2'b00);
    rd(SSR_R_FMP, 16'h1800);
    run(SSR_OP_WRITE, SSR_R_LIM, 16'hffff, 2'b00);
    run(SSR_OP_WRITE, SSR_R_SMT, 16'hfffe, 2'b00);
    chk("top wrap", 16'h0002, logical_top);
    $display("t_stack done");
  endtask

  task automatic t_code();
    program_base = 16'h0100;
    program_limit = 16'h01ff;
    pc_target = 16'h0150;
    run(SSR_OP_PCSET, 4'h0, 16'h0000, 2'b00);
    chk("pc", 16'h0150, program_counter);
    pc_target = 16'h0200;
    run(SSR_OP_PCSET, 4'h0, 16'h0000, 2'b00);
    chk("pc fault", 16'h0001, {15'h0, pc_violation});
    chk("pc kept", 16'h0150, program_counter);
    ins = 16'h0025;
    run(SSR_OP_WRITE, SSR_R_IDX, 16'h0005, 2'b00);
    chk("pc fwd", 16'h0175, eff_addr);
    chk("pc rel", 16'h0075, rel_addr);
    use_index = 1'b1;
    #1 chk("indexed", 16'h017a, eff_addr);
    use_index = 1'b0;
    program_base = 16'h0000;
    program_limit = 16'hffff;
    pc_target = 16'hfff0;
    run(SSR_OP_PCSET, 4'h0, 16'h0000, 2'b00);
    chk("pc wrap", 16'h0015, eff_addr);
    ins = 16'h00c8;
    #1 chk("pc fwd 8b", 16'h00b8, eff_addr);
    ins = 16'h0110;
    #1 chk("pc back", 16'hffe0, eff_addr);
    ins = 16'h0285;
    #1 chk("db fwd", 16'h1085, eff_addr);
    chk("db rel", 16'h0085, rel_addr);
    chk("tos miss", 16'h0000, {15'h0, in_tos});
    run(SSR_OP_LRA, 4'h0, 16'h0000, 2'b00);
    chk("lra", 16'h0085, rd_data);
    ins = 16'h0345;
    #1 chk("fm fwd", 16'h1845, eff_addr);
    ins = 16'h0382;
    #1 chk("fm back", 16'h17fe, eff_addr);
    ins = 16'h03c3;
    #1 chk("st back", 16'hffff, eff_addr);
    chk("tos hit", 16'h000b, {12'h0, in_tos, tos_slot});
    $display("t_code done");
  endtask

  task automatic t_mask();
    run(SSR_OP_LMSK, 4'h0, 16'h00ff, 2'b00);
    ext_irq = 16'h0f0f;
    repeat (4) @(negedge sys_clk);
    chk("irq", 16'h000f, irq_enabled);
    rd(SSR_R_MASK, 16'h00ff);
    $display("t_mask done");
  endtask

  task automatic t_user();
    ssr_op_t pl[3] = '{SSR_OP_PRIV, SSR_OP_UCALL, SSR_OP_ABS};
    foreach (pl[i]) run(pl[i], 4'h0, 16'h0000, 2'b00);
    run(SSR_OP_WRITE, SSR_R_STAT, 16'h0000, 2'b00);
    chk("user", 16'h0000, {15'h0, priv_mode});
    foreach (pl[i]) run(pl[i], 4'h0, 16'h0000, 2'b10);
    run(SSR_OP_WRITE, SSR_R_DB, 16'h3000, 2'b10);
    rd(SSR_R_DB, 16'h1000);
    run(SSR_OP_LMSK, 4'h0, 16'h0000, 2'b10);
    run(SSR_OP_READ_INTERRUPT_MASK_OP, 4'h0, 16'h0000, 2'b00);
    chk("read_interrupt_mask_op", 16'h00ff, rd_data);
    rd(SSR_R_MASK, 16'h00ff);
    run(SSR_OP_WRITE, SSR_R_SMT, 16'h0800, 2'b01);
    run(SSR_OP_WRITE, SSR_R_IDX, 16'hbeef, 2'b00);
    clk_en = 1'b0;
    run(SSR_OP_WRITE, SSR_R_IDX, 16'h0001, 2'b00);
    clk_en = 1'b1;
    rd(SSR_R_IDX, 16'hbeef);
    chk("still user", 16'h0000, {15'h0, priv_mode});
    $display("t_user done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #50us;
    err_total++;
    test_done();
  end

  // Main sequence
  initial
  begin
    {rst_n, use_index, reg_sel, wr_data, ins, program_base, pc_target, ext_irq} = '0;
    clk_en = 1'b1;
    op = SSR_OP_NONE;
    program_limit = 16'hffff;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset();
    t_stack();
    t_code();
    t_mask();
    t_user();
    test_done();
  end
endmodule
